/* File: rtl/ofm_monitor.sv */
// Oscillator fail monitor: frequency supervision, clock switch, fail-safe reset and wake-up control
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ofm_map.svh"

// Overview of operation
// - Divide the RC reference by ten; main oscillator slower than that is a failure.
// - On failure, select the RC oscillator as the system clock source.
// - Assert chip reset one clock after the clock source switches to RC.
// - Failure reset acts like external reset but keeps the timer status flag; stops watchdog.
// - Hardware sets the oscillator failure flag on a failure reset from the run state, not at power-on.
// - On recovery, hold reset and RC clock for a 1 ms final phase.
// - After the final phase, select the main oscillator and drop our reset request.
// - Chip reset stays while external or watchdog reset is still requested.
// - With no reset left, execution restarts at address zero.
// - Software can set and clear the oscillator failure flag by writing.
// - External reset clears the oscillator failure and timer reset status flags.
// - In power-down both the RC and the main oscillator are stopped.
// - Wake only when wake enable is set and the selected source is active.
// - Wake source select picks exactly one source: wake pin or RTC flag.
// - No reset during oscillator start-up after a power-down wake-up.
// - After the main oscillator outruns the reference, wait 1 ms, then raise wake interrupt.
// - At power-on the monitor sees failure, clocks from RC and resets the chip.
// - The monitor is always enabled; nothing turns it off.
module ofm_monitor #(
  parameter int unsigned FINAL_RESET_CYCLES = `OFM_FINAL_RESET_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire ofm_pkg::ofm_bus_req_type bus_req,
  output logic [`OFM_DATA_W-1:0]       bus_rdata,
  input  wire logic                    main_osc_in,
  input  wire logic                    rc_osc_in,
  input  wire logic                    ext_reset_req_n,
  input  wire logic                    wdt_reset_req,
  input  wire logic                    wdt_reset_event,
  input  wire logic                    powerdown_req,
  input  wire logic                    external_wake_pin,
  input  wire logic                    rtc_interrupt_flag,
  output logic                         clk_sel_rc,
  output logic                         osc_enable,
  output logic                         chip_reset,
  output logic                         wdt_stop,
  output logic                         restart_pulse,
  output logic [15:0]                  restart_addr,
  output logic                         wake_irq,
  output logic                         irq
);

  // Two-flop synchronisers for pins and the two oscillator inputs
  logic [1:0] main_sync_q;
  logic [1:0] rc_sync_q;
  logic [1:0] ext_rst_sync_q;
  logic [1:0] wake_pin_sync_q;
  logic       main_prev_q;
  logic       rc_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_sync_q     <= 2'h0;
      rc_sync_q       <= 2'h0;
      ext_rst_sync_q  <= 2'h3;
      wake_pin_sync_q <= 2'h3;
      main_prev_q     <= 1'b0;
      rc_prev_q       <= 1'b0;
    end else begin
      main_sync_q     <= {main_sync_q[0], main_osc_in};
      rc_sync_q       <= {rc_sync_q[0], rc_osc_in};
      ext_rst_sync_q  <= {ext_rst_sync_q[0], ext_reset_req_n};
      wake_pin_sync_q <= {wake_pin_sync_q[0], external_wake_pin};
      main_prev_q     <= main_sync_q[1];
      rc_prev_q       <= rc_sync_q[1];
    end
  end

  logic main_rise;
  logic rc_rise;
  logic ext_reset;
  assign main_rise = main_sync_q[1] & ~main_prev_q;
  assign rc_rise   = rc_sync_q[1] & ~rc_prev_q;
  assign ext_reset = ~ext_rst_sync_q[1];

  // Edge-count window: ten RC edges form one reference period
  logic [3:0]               rc_cnt_q;
  logic                     main_seen_q;
  ofm_pkg::ofm_verdict_type verdict_q;
  ofm_pkg::ofm_state_type   state_q;
  logic                     window_end;

  assign window_end = rc_rise && (rc_cnt_q == `OFM_RC_DIVIDE - 4'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_cnt_q    <= 4'h0;
      main_seen_q <= 1'b0;
      verdict_q   <= '0;
    end else if (state_q == ofm_pkg::OFM_ST_POWERDOWN) begin
      // Oscillators are stopped, so no verdict can be trusted
      rc_cnt_q    <= 4'h0;
      main_seen_q <= 1'b0;
      verdict_q   <= '0;
    end else begin
      verdict_q <= '0;
      if (window_end) begin
        rc_cnt_q       <= 4'h0;
        main_seen_q    <= main_rise;
        verdict_q.fail <= ~(main_seen_q | main_rise);
        verdict_q.good <= main_seen_q | main_rise;
      end else begin
        if (rc_rise) begin
          rc_cnt_q <= rc_cnt_q + 4'h1;
        end
        if (main_rise) begin
          main_seen_q <= 1'b1;
        end
      end
    end
  end

  // Registers reachable by software
  logic [`OFM_DATA_W-1:0] failsafe_q;
  logic [`OFM_DATA_W-1:0] pwr_ctrl_q;
  logic [`OFM_IRQ_W-1:0]  irq_status_q;
  logic [`OFM_IRQ_W-1:0]  irq_mask_q;

  function automatic logic is_write(input ofm_pkg::ofm_bus_req_type r, input logic [7:0] a);
    is_write = r.wr && (r.addr == a);
  endfunction

  // Sequencer
  localparam int unsigned CNT_W = $clog2(FINAL_RESET_CYCLES + 1);
  logic [CNT_W-1:0] delay_q;
  logic             osc_reset_q;
  logic             fail_event;
  logic             recover_event;
  logic             wake_event;
  logic             wake_source;
  logic             delay_done;

  // Exactly one source is looked at; a low pin level wakes
  assign wake_source = pwr_ctrl_q[`OFM_BIT_WAKE_SOURCE] ? rtc_interrupt_flag
                                                         : ~wake_pin_sync_q[1];
  assign delay_done  = (delay_q == CNT_W'(FINAL_RESET_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ofm_pkg::OFM_ST_FAIL;
      delay_q     <= '0;
      osc_reset_q <= 1'b1;
      clk_sel_rc  <= 1'b1;
      osc_enable  <= 1'b1;
    end else begin
      case (state_q)
        ofm_pkg::OFM_ST_FAIL: begin
          delay_q <= '0;
          if (verdict_q.good) begin
            state_q <= ofm_pkg::OFM_ST_FINAL;
          end
        end
        ofm_pkg::OFM_ST_FINAL: begin
          if (verdict_q.fail) begin
            state_q <= ofm_pkg::OFM_ST_FAIL;
            delay_q <= '0;
          end else if (delay_done) begin
            state_q     <= ofm_pkg::OFM_ST_RUN;
            clk_sel_rc  <= 1'b0;
            osc_reset_q <= 1'b0;
          end else begin
            delay_q <= delay_q + CNT_W'(1);
          end
        end
        ofm_pkg::OFM_ST_RUN: begin
          if (verdict_q.fail) begin
            state_q     <= ofm_pkg::OFM_ST_FAIL;
            clk_sel_rc  <= 1'b1;
            osc_reset_q <= 1'b1;
          end else if (powerdown_req) begin
            state_q    <= ofm_pkg::OFM_ST_POWERDOWN;
            osc_enable <= 1'b0;
          end
        end
        ofm_pkg::OFM_ST_POWERDOWN: begin
          if (pwr_ctrl_q[`OFM_BIT_WAKE_ENABLE] && wake_source) begin
            state_q    <= ofm_pkg::OFM_ST_WAKE_START;
            osc_enable <= 1'b1;
            clk_sel_rc <= 1'b1;
          end
        end
        ofm_pkg::OFM_ST_WAKE_START: begin
          // Slow main oscillator here is start-up, not failure
          delay_q <= '0;
          if (verdict_q.good) begin
            state_q <= ofm_pkg::OFM_ST_WAKE_DELAY;
          end
        end
        ofm_pkg::OFM_ST_WAKE_DELAY: begin
          if (delay_done) begin
            state_q    <= ofm_pkg::OFM_ST_RUN;
            clk_sel_rc <= 1'b0;
          end else begin
            delay_q <= delay_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= ofm_pkg::OFM_ST_FAIL;
        end
      endcase
    end
  end

  assign fail_event    = (state_q == ofm_pkg::OFM_ST_RUN) && verdict_q.fail;
  assign recover_event = (state_q == ofm_pkg::OFM_ST_FINAL) && !verdict_q.fail && delay_done;
  assign wake_event    = (state_q == ofm_pkg::OFM_ST_WAKE_DELAY) && delay_done;

  // Chip reset combines our request with the other sources
  logic chip_reset_d;
  assign chip_reset_d = osc_reset_q | ext_reset | wdt_reset_req;

  // Registered so the reset tree never sees a glitch from the OR of sources
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset <= 1'b1;
    end else begin
      chip_reset <= chip_reset_d;
    end
  end

  // Own and external reset stop the watchdog; its own request does not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_stop <= 1'b1;
    end else begin
      wdt_stop <= osc_reset_q | ext_reset;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_pulse <= 1'b0;
    end else begin
      restart_pulse <= chip_reset & ~chip_reset_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_addr <= `OFM_RESTART_ADDR;
    end else begin
      restart_addr <= `OFM_RESTART_ADDR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= wake_event;
    end
  end

  // Fail-safe status: hardware set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      failsafe_q <= `OFM_FAILSAFE_RESET;
    end else begin
      if (is_write(bus_req, `OFM_REG_FAILSAFE)) begin
        failsafe_q <= bus_req.wdata;
      end
      if (ext_reset) begin
        failsafe_q[`OFM_BIT_OSC_STATUS]   <= 1'b0;
        failsafe_q[`OFM_BIT_TIMER_STATUS] <= 1'b0;
      end
      if (wdt_reset_event) begin
        failsafe_q[`OFM_BIT_TIMER_STATUS] <= 1'b1;
      end
      if (fail_event) begin
        failsafe_q[`OFM_BIT_OSC_STATUS] <= 1'b1;
      end
    end
  end

  // Power control extension: wake enable and source select only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctrl_q <= `OFM_PWR_CTRL_RESET;
    end else if (is_write(bus_req, `OFM_REG_PWR_CTRL_EXT)) begin
      pwr_ctrl_q <= bus_req.wdata & 8'h90;
    end
  end

  // Interrupt status, write one to clear, set wins
  logic [`OFM_IRQ_W-1:0] irq_set;
  logic [`OFM_IRQ_W-1:0] irq_clr;
  assign irq_set = {wake_event, recover_event, fail_event};
  assign irq_clr = is_write(bus_req, `OFM_REG_IRQ_STATUS) ? bus_req.wdata[`OFM_IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (is_write(bus_req, `OFM_REG_IRQ_MASK)) begin
      irq_mask_q <= bus_req.wdata[`OFM_IRQ_W-1:0];
    end
  end

  // Built from the next status so the line follows a set or clear without lag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (!bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.addr == `OFM_REG_FAILSAFE) begin
      bus_rdata <= failsafe_q;
    end else if (bus_req.addr == `OFM_REG_PWR_CTRL_EXT) begin
      bus_rdata <= pwr_ctrl_q;
    end else if (bus_req.addr == `OFM_REG_IRQ_STATUS) begin
      bus_rdata <= {5'h00, irq_status_q};
    end else if (bus_req.addr == `OFM_REG_IRQ_MASK) begin
      bus_rdata <= {5'h00, irq_mask_q};
    end else if (bus_req.addr == `OFM_REG_MON_STATE) begin
      // No enable bit exists anywhere: the monitor cannot be switched off
      bus_rdata <= {clk_sel_rc, osc_reset_q, osc_enable, 2'h0, state_q};
    end else begin
      bus_rdata <= 8'h00;
    end
  end

endmodule // ofm_monitor

`default_nettype wire

/* File: rtl/ofm_map.svh */
// Offsets, field positions, reset values and timing counts of the oscillator fail monitor
`ifndef OFM_MAP_SVH
`define OFM_MAP_SVH

`define OFM_ADDR_W             8
`define OFM_DATA_W             8

`define OFM_REG_FAILSAFE       8'ha9
`define OFM_REG_PWR_CTRL_EXT   8'hc8
`define OFM_REG_IRQ_STATUS     8'hc9
`define OFM_REG_IRQ_MASK       8'hca
`define OFM_REG_MON_STATE      8'hcb

`define OFM_FAILSAFE_RESET     8'h00
`define OFM_BIT_TIMER_STATUS   6
`define OFM_BIT_OSC_STATUS     5
`define OFM_BIT_WAKE_ENABLE    7
`define OFM_BIT_WAKE_SOURCE    4
`define OFM_PWR_CTRL_RESET     8'h00

`define OFM_IRQ_W              3
`define OFM_IRQ_FAIL           0
`define OFM_IRQ_RECOVER        1
`define OFM_IRQ_WAKE           2

`define OFM_RC_DIVIDE          4'd10
`define OFM_CLK_PERIOD_PS      4000
`define OFM_FINAL_RESET_PS     1000000000
`define OFM_FINAL_RESET_CYC    (`OFM_FINAL_RESET_PS / `OFM_CLK_PERIOD_PS)
`define OFM_RESTART_ADDR       16'h0000

`endif

/* File: rtl/ofm_pkg.sv */
// Types shared by the oscillator fail monitor
package ofm_pkg;

  typedef enum logic [2:0] {
    OFM_ST_FAIL,
    OFM_ST_FINAL,
    OFM_ST_RUN,
    OFM_ST_POWERDOWN,
    OFM_ST_WAKE_START,
    OFM_ST_WAKE_DELAY
  } ofm_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ofm_bus_req_type;

  typedef struct packed {
    logic fail;
    logic good;
  } ofm_verdict_type;

endpackage

/* File: sim/ofm_chk_monitor.sv */
// Concurrent checks on the oscillator fail monitor ports
`timescale 1ns/1ps
`default_nettype none
`include "ofm_map.svh"
module ofm_chk #(
  parameter int unsigned FINAL_RESET_CYCLES = 20
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire ofm_pkg::ofm_bus_req_type bus_req,
  input wire logic [`OFM_DATA_W-1:0]   bus_rdata,
  input wire logic                     main_osc_in,
  input wire logic                     rc_osc_in,
  input wire logic                     ext_reset_req_n,
  input wire logic                     wdt_reset_req,
  input wire logic                     wdt_reset_event,
  input wire logic                     powerdown_req,
  input wire logic                     external_wake_pin,
  input wire logic                     rtc_interrupt_flag,
  input wire logic                     clk_sel_rc,
  input wire logic                     osc_enable,
  input wire logic                     chip_reset,
  input wire logic                     wdt_stop,
  input wire logic                     restart_pulse,
  input wire logic [15:0]              restart_addr,
  input wire logic                     wake_irq,
  input wire logic                     irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts cycles on the RC source; long counts cannot be a repetition
  logic [31:0] rc_cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rc_cnt_q <= '0;
    else if (clk_sel_rc) rc_cnt_q <= rc_cnt_q + 32'd1;
    else rc_cnt_q <= '0;
  end
  AST_RST_FOLLOWS_SEL: assert property ($rose(clk_sel_rc) && osc_enable && $past(osc_enable) |=> chip_reset)
    else $error("chip reset missing after clock switch");
  AST_SEL_BEFORE_DROP: assert property ($fell(chip_reset) |-> !clk_sel_rc)
    else $error("reset released while on RC clock");
  AST_FINAL_LEN: assert property ($fell(clk_sel_rc) |-> rc_cnt_q >= FINAL_RESET_CYCLES)
    else $error("final phase too short");
  AST_WDT_HOLD: assert property (chip_reset && wdt_reset_req |=> chip_reset)
    else $error("reset dropped during watchdog request");
  AST_EXT_HOLD: assert property (!ext_reset_req_n [*4] |-> chip_reset)
    else $error("reset missing during external request");
  AST_RESTART_ON_FALL: assert property (restart_pulse |-> $fell(chip_reset))
    else $error("restart without reset release");
  AST_RESTART_ADDR: assert property (restart_addr == `OFM_RESTART_ADDR)
    else $error("restart address not zero");
  AST_WAKE_NO_RST: assert property (wake_irq |-> !chip_reset && !$past(chip_reset))
    else $error("reset during wake-up");
  AST_WAKE_PULSE: assert property (wake_irq |=> !wake_irq)
    else $error("wake interrupt longer than one cycle");
  AST_WDT_STOP: assert property (chip_reset && $past(chip_reset) && clk_sel_rc |-> wdt_stop)
    else $error("watchdog running in failure reset");
  cover property ($fell(chip_reset));
  cover property ($rose(clk_sel_rc));
  cover property (wake_irq);
endmodule // ofm_chk
bind ofm_monitor ofm_chk #(.FINAL_RESET_CYCLES(FINAL_RESET_CYCLES)) u_ofm_chk (
  .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .main_osc_in(main_osc_in),
  .rc_osc_in(rc_osc_in), .ext_reset_req_n(ext_reset_req_n), .wdt_reset_req(wdt_reset_req),
  .wdt_reset_event(wdt_reset_event), .powerdown_req(powerdown_req), .external_wake_pin(external_wake_pin),
  .rtc_interrupt_flag(rtc_interrupt_flag), .clk_sel_rc(clk_sel_rc), .osc_enable(osc_enable),
  .chip_reset(chip_reset), .wdt_stop(wdt_stop), .restart_pulse(restart_pulse),
  .restart_addr(restart_addr), .wake_irq(wake_irq), .irq(irq));
`default_nettype wire

/* File: sim/ofm_osc_model.sv */
// Behavioural main crystal and RC reference oscillators
`timescale 1ns/1ps
`default_nettype none
module ofm_osc_model (
  input  wire logic osc_enable,
  input  wire logic main_run,
  output logic      main_osc_in,
  output logic      rc_osc_in
);
  initial begin
    main_osc_in = 1'b0;
    rc_osc_in = 1'b0;
  end
  // RC runs as soon as enabled, even before the crystal both stand still when stopped
  always #20 rc_osc_in = osc_enable ? ~rc_osc_in : 1'b0;
  always #12 main_osc_in = (osc_enable && main_run) ? ~main_osc_in : 1'b0;
endmodule // ofm_osc_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the oscillator fail monitor
`timescale 1ns/1ps
`default_nettype none
`include "ofm_map.svh"
module testbench;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  ofm_pkg::ofm_bus_req_type req = '0;
  logic [7:0]               rdata, d, s;
  logic                     main_osc, rc_osc, main_run = 1'b0, ext_n = 1'b1, wdt_req = 1'b0, wdt_ev = 1'b0;
  logic                     pd_req = 1'b0, wake_pin = 1'b1, rtc_flag = 1'b0, in_pd = 1'b0, saw_rst = 1'b0;
  logic                     clk_sel_rc, osc_enable, chip_reset, wdt_stop, restart_pulse, wake_irq, irq;
  logic [15:0]              restart_addr;
  int                       miscompares = 0, n_tests = 0, exp_reg [256];
  always #2 clk = ~clk;
  ofm_monitor #(.FINAL_RESET_CYCLES(20)) u_ofm_monitor (.clk(clk), .rst_n(rst_n), .bus_req(req),
    .bus_rdata(rdata), .main_osc_in(main_osc), .rc_osc_in(rc_osc), .ext_reset_req_n(ext_n),
    .wdt_reset_req(wdt_req), .wdt_reset_event(wdt_ev), .powerdown_req(pd_req), .external_wake_pin(wake_pin),
    .rtc_interrupt_flag(rtc_flag), .clk_sel_rc(clk_sel_rc), .osc_enable(osc_enable), .chip_reset(chip_reset),
    .wdt_stop(wdt_stop), .restart_pulse(restart_pulse), .restart_addr(restart_addr), .wake_irq(wake_irq), .irq(irq));
  ofm_osc_model u_ofm_osc_model (.osc_enable(osc_enable), .main_run(main_run), .main_osc_in(main_osc),
    .rc_osc_in(rc_osc));
  always @(posedge clk) if (in_pd && chip_reset === 1'b1) saw_rst <= 1'b1;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 chk({8'h00, rdata & m}, 16'(exp_reg[a] & m));
  endtask
  task automatic wait_on(input int w, input logic v, input int lim);
    logic x;
    for (int i = 0; i <= lim; i++) begin
      @(posedge clk);
      #1 x = (w == 0) ? chip_reset : (w == 1) ? clk_sel_rc : (w == 2) ? osc_enable : wake_irq;
      if (x === v) return;
    end
    miscompares++;
    $display("[ERR] %0t wait %0d timed out", $time, w);
    summarize();
  endtask
  initial begin
    void'($urandom(11));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({clk_sel_rc, chip_reset}, 16'h0003);
    repeat (50) @(posedge clk);
    main_run <= 1'b1;
    exp_reg[8'ha9] = 8'h00;
    exp_reg[8'hc9] = 8'h02;
    wait_on(0, 1'b0, 1000);
    chk(restart_pulse, 1'b1);
    rd_chk(8'ha9, 8'hff);
    rd_chk(8'hc9, 8'hff);
    rd_chk(8'h3c, 8'hff);
    exp_reg[8'hcb] = 8'h20;
    rd_chk(8'hcb, 8'he0);
    chk(irq, 1'b0);
    $display("test power_on done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom());
      wr(8'ha9, d);
      exp_reg[8'ha9] = d;
      rd_chk(8'ha9, 8'hff);
    end
    wr(8'ha9, 8'h60);
    ext_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk(chip_reset, 1'b1);
    @(posedge clk) ext_n <= 1'b1;
    exp_reg[8'ha9] = 0;
    wait_on(0, 1'b0, 50);
    rd_chk(8'ha9, 8'h60);
    $display("test flags done");
    wr(8'hc9, 8'hff);
    wr(8'hca, 8'h07);
    @(posedge clk) wdt_ev <= 1'b1;
    @(posedge clk) wdt_ev <= 1'b0;
    main_run <= 1'b0;
    exp_reg[8'ha9] = 8'h60;
    exp_reg[8'hc9] = 8'h01;
    wait_on(0, 1'b1, 1000);
    chk({clk_sel_rc, wdt_stop}, 16'h0003);
    @(posedge clk) wdt_req <= 1'b1;
    rd_chk(8'ha9, 8'hff);
    rd_chk(8'hc9, 8'hff);
    chk(irq, 1'b1);
    main_run <= 1'b1;
    wait_on(1, 1'b0, 1000);
    repeat (8) @(posedge clk);
    #1 chk(chip_reset, 1'b1);
    @(posedge clk) wdt_req <= 1'b0;
    wait_on(0, 1'b0, 10);
    chk(restart_pulse, 1'b1);
    wr(8'hc9, 8'hff);
    exp_reg[8'hc9] = 0;
    rd_chk(8'hc9, 8'hff);
    chk(irq, 1'b0);
    $display("test failure done");
    for (int k = 0; k < 2; k++) begin
      s = (k == 1) ? 8'h10 : 8'h00;
      wr(8'hc8, s);
      @(posedge clk) pd_req <= 1'b1;
      @(posedge clk) pd_req <= 1'b0;
      wait_on(2, 1'b0, 20);
      in_pd = 1'b1;
      @(posedge clk) wake_pin <= (k != 0);
      rtc_flag <= (k == 1);
      repeat (40) @(posedge clk);
      #1 chk(osc_enable, 1'b0);
      @(posedge clk) wake_pin <= (k == 0);
      rtc_flag <= (k == 0);
      wr(8'hc8, s | 8'h80);
      exp_reg[8'hc8] = s | 8'h80;
      rd_chk(8'hc8, 8'hff);
      repeat (40) @(posedge clk);
      #1 chk(osc_enable, 1'b0);
      @(posedge clk) wake_pin <= (k != 0);
      rtc_flag <= (k == 1);
      wait_on(2, 1'b1, 50);
      wait_on(3, 1'b1, 1000);
      in_pd = 1'b0;
      chk(saw_rst, 1'b0);
      @(posedge clk) wake_pin <= 1'b1;
      rtc_flag <= 1'b0;
      exp_reg[8'hc9] = 8'h04;
      rd_chk(8'hc9, 8'hff);
      wr(8'hc9, 8'hff);
      $display("test wake source %0d done", k);
    end
    summarize();
  end
endmodule // testbench
`default_nettype wire
